// ===== rtl/adcsq_regs.svh
/*
 * Fixed numbers of the converter control sequencer: command byte fields,
 * mode codes, reset values and timing.
 * Assumes it is included by the top module only.
 */
`ifndef ADCSQ_REGS_SVH
`define ADCSQ_REGS_SVH

// ****************************************************************
// command byte layout
// ****************************************************************
`define ADCSQ_START_BIT 7
`define ADCSQ_CHAN_HI 6
`define ADCSQ_UNI_BIT 3
`define ADCSQ_SGL_BIT 2
`define ADCSQ_MODE_HI 1
`define ADCSQ_CMD_BITS 4'h8
`define ADCSQ_TRACK_AFTER 4'h5
`define ADCSQ_ROUTE_AFTER 4'h6

// ****************************************************************
// mode codes and reset values
// ****************************************************************
`define ADCSQ_MODE_FULLPD 2'h0
`define ADCSQ_MODE_FASTPD 2'h1
`define ADCSQ_MODE_INT 2'h2
`define ADCSQ_MODE_EXT 2'h3
`define ADCSQ_RST_MODE 2'h2
`define ADCSQ_RST_STROBE 1'h1
`define ADCSQ_RES_BITS 10
`define ADCSQ_PAD_BITS 6

// ****************************************************************
// timing
// ****************************************************************
`define ADCSQ_CLK_MHZ 200
`define ADCSQ_STEP_NS 560

`endif

// ===== rtl/adcsq_pkg.sv
/*
 * Types of the converter control sequencer.
 * Assumes nothing beyond the constant header.
 */
package adcsq_pkg;

  // ****************************************************************
  // states
  // ****************************************************************
  typedef enum logic [2:0] {
    RX_SEARCH = 3'h1,
    RX_CMD = 3'h2,
    RX_WAIT = 3'h4
  } adcsq_rx_e;

  typedef enum logic [3:0] {
    CV_IDLE = 4'h1,
    CV_EXT = 4'h2,
    CV_INT = 4'h4,
    CV_DONE = 4'h8
  } adcsq_cv_e;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [1:0] pos;
    logic [1:0] neg;
    logic neg_com;
  } adcsq_route_s;

endpackage : adcsq_pkg

// ===== rtl/adcsq_buf.sv
/*
 * Small valid/ready buffer holding finished conversion words.
 * Assumes both sides run on i_mclk.
 */
`timescale 1ns/1ps
module adcsq_buf #(
  parameter int W = 10,
  parameter int DEPTH = 2
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp, next_wp, rp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic push, pop;

  assign o_ready = (cnt != (AW+1)'(DEPTH));
  assign o_valid = (cnt != '0);
  assign o_data = mem[rp];

  // ****************************************************************
  // pointers
  // ****************************************************************
  always_comb begin
    push = i_valid && o_ready;
    pop = o_valid && i_ready;
    next_wp = wp;
    next_rp = rp;
    next_cnt = cnt;
    if (push) begin
      next_wp = (wp == AW'(DEPTH - 1)) ? '0 : wp + AW'(1);
    end
    if (pop) begin
      next_rp = (rp == AW'(DEPTH - 1)) ? '0 : rp + AW'(1);
    end
    if (push && !pop) begin
      next_cnt = cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      next_cnt = cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end

  // storage needs no reset; empty words are never presented
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wp] <= i_data;
    end
  end

endmodule : adcsq_buf

// ===== rtl/adcsq_top.sv
/*
 * Serial control port and conversion sequencer of a four-input 10-bit
 * successive-approximation converter, run on the fast system clock.
 * Assumes the serial pins come from an external master and are synced
 * here, and that the analog comparator answers within a few clocks.
 */
`timescale 1ns/1ps
`include "adcsq_regs.svh"

module adcsq_top #(
  parameter int RES_W = `ADCSQ_RES_BITS,
  parameter int STEP_CYC = (`ADCSQ_STEP_NS * `ADCSQ_CLK_MHZ) / 1000
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_sclk,
  input wire logic i_csn,
  input wire logic i_din,
  input wire logic i_comp_high,
  output logic o_dout,
  output logic o_dout_oe,
  output logic o_strobe,
  output logic o_strobe_oe,
  output logic o_track,
  output logic o_unipolar,
  output logic o_converting,
  output logic [1:0] o_mode,
  output logic [RES_W-1:0] o_dac_code,
  output adcsq_pkg::adcsq_route_s o_route
);
  import adcsq_pkg::*;

  localparam int OW = RES_W + `ADCSQ_PAD_BITS;
  localparam logic [RES_W-1:0] MID = {1'b1, {(RES_W-1){1'b0}}};
  localparam logic [15:0] STEP_LAST = 16'(STEP_CYC - 1);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic adcsq_route_s route_of(input logic [2:0] ch,
                                            input logic sgl);
    adcsq_route_s r;
    r.pos = {ch[1], ch[2]};
    r.neg = {ch[1], ~ch[2]};
    r.neg_com = sgl;
    return r;
  endfunction : route_of

  function automatic logic [RES_W-1:0] fmt(input logic [RES_W-1:0] c,
                                           input logic uni);
    return uni ? c : {~c[RES_W-1], c[RES_W-2:0]};
  endfunction : fmt

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [1:0] sclk_m, csn_m, din_m, comp_m;
  logic sclk_d;
  wire sclk_s = sclk_m[1];
  wire csn_s = csn_m[1];
  wire din_s = din_m[1];
  wire comp_s = comp_m[1];
  wire sclk_rise = sclk_s && !sclk_d;
  wire sclk_fall = !sclk_s && sclk_d;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_m <= 2'h0;
      csn_m <= 2'h3;
      din_m <= 2'h0;
      comp_m <= 2'h0;
      sclk_d <= 1'b0;
    end else begin
      sclk_m <= {sclk_m[0], i_sclk};
      csn_m <= {csn_m[0], i_csn};
      din_m <= {din_m[0], i_din};
      comp_m <= {comp_m[0], i_comp_high};
      sclk_d <= sclk_s;
    end
  end

  // ****************************************************************
  // command receiver
  // ****************************************************************
  adcsq_rx_e rx_state, next_rx_state;
  logic [7:0] cmd_sr, next_cmd_sr;
  logic [3:0] rx_cnt, next_rx_cnt;
  logic track, next_track;
  adcsq_route_s route, next_route;
  logic cmd_done;

  always_comb begin
    next_rx_state = rx_state;
    next_cmd_sr = cmd_sr;
    next_rx_cnt = rx_cnt;
    next_track = track;
    next_route = route;
    cmd_done = 1'b0;
    if (csn_s) begin
      next_rx_state = RX_SEARCH;
      next_rx_cnt = 4'h0;
    end else begin
      unique case (rx_state)
        RX_SEARCH: if (sclk_rise && din_s) begin
          next_rx_state = RX_CMD;
          next_cmd_sr = 8'h01;
          next_rx_cnt = 4'h1;
        end
        RX_CMD: begin
          if (sclk_rise) begin
            next_cmd_sr = {cmd_sr[6:0], din_s};
            next_rx_cnt = rx_cnt + 4'h1;
            if (rx_cnt == `ADCSQ_CMD_BITS - 4'h1) begin
              next_rx_state = RX_WAIT;
            end
          end
          if (sclk_fall && rx_cnt == `ADCSQ_TRACK_AFTER) begin
            next_track = 1'b1;
          end
          if (sclk_fall && rx_cnt == `ADCSQ_ROUTE_AFTER) begin
            // channel and input type known after six bits
            next_route = route_of(cmd_sr[4:2], cmd_sr[0]);
          end
        end
        RX_WAIT: if (sclk_fall) begin
          cmd_done = 1'b1;
          next_track = 1'b0;
          next_rx_state = RX_SEARCH;
          next_rx_cnt = 4'h0;
        end
        default: next_rx_state = RX_SEARCH;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_state <= RX_SEARCH;
      cmd_sr <= 8'h00;
      rx_cnt <= 4'h0;
      track <= 1'b0;
      route <= '0;
    end else begin
      rx_state <= next_rx_state;
      cmd_sr <= next_cmd_sr;
      rx_cnt <= next_rx_cnt;
      track <= next_track;
      route <= next_route;
    end
  end

  // ****************************************************************
  // conversion and shift-out
  // ****************************************************************
  adcsq_cv_e cv_state, next_cv_state;
  logic [RES_W-1:0] trial, next_trial;
  logic [3:0] idx, next_idx;
  logic [15:0] div, next_div;
  logic [1:0] mode, next_mode;
  logic uni, next_uni;
  logic strobe, next_strobe, dout, next_dout;
  logic converting, next_converting;
  logic [OW-1:0] osr, next_osr;
  logic [4:0] ocnt, next_ocnt;
  logic step, bit_now, push, pop, buf_in_ready, buf_out_valid;
  logic [RES_W-1:0] buf_out;

  always_comb begin
    next_cv_state = cv_state;
    next_trial = trial;
    next_idx = idx;
    next_div = div;
    next_mode = mode;
    next_uni = uni;
    next_strobe = strobe;
    next_dout = dout;
    next_osr = osr;
    next_ocnt = ocnt;
    push = 1'b0;
    // ready only while no shift edge competes with the load
    pop = buf_out_valid && ocnt == 5'h0 && !sclk_fall;
    // external steps ride the host clock, internal ones the divider
    step = (cv_state == CV_EXT) ? sclk_fall :
           (cv_state == CV_INT && div == 16'h0);
    bit_now = comp_s;
    if (cv_state == CV_INT) begin
      next_div = (div == 16'h0) ? STEP_LAST : div - 16'h1;
    end
    if (pop) begin
      next_osr = {buf_out, {`ADCSQ_PAD_BITS{1'b0}}};
      next_ocnt = 5'(OW);
    end else if (sclk_fall && !csn_s && cv_state != CV_EXT) begin
      next_dout = osr[OW-1];
      next_osr = {osr[OW-2:0], 1'b0};
      if (ocnt != 5'h0) begin
        next_ocnt = ocnt - 5'h1;
      end
    end
    if (csn_s && mode == `ADCSQ_MODE_EXT) begin
      next_strobe = 1'b0;
    end
    if (cmd_done) begin
      next_mode = cmd_sr[`ADCSQ_MODE_HI:0];
      next_uni = cmd_sr[`ADCSQ_UNI_BIT];
      next_trial = MID;
      next_idx = 4'(RES_W - 1);
      unique case (cmd_sr[`ADCSQ_MODE_HI:0])
        `ADCSQ_MODE_EXT: begin
          next_cv_state = CV_EXT;
          next_strobe = 1'b1;
          next_dout = 1'b0;
          next_ocnt = 5'h0;
          next_osr = '0;
        end
        `ADCSQ_MODE_INT: begin
          next_cv_state = CV_INT;
          next_strobe = 1'b0;
          next_div = STEP_LAST;
        end
        default: next_cv_state = CV_IDLE;
      endcase
    end else if (step) begin
      // keep the decided bit, try the next lower one
      next_trial[idx] = bit_now;
      if (idx != 4'h0) begin
        next_trial[idx - 4'h1] = 1'b1;
      end
      next_idx = idx - 4'h1;
      if (cv_state == CV_EXT) begin
        next_strobe = 1'b0;
        next_dout = (idx == 4'(RES_W - 1)) ? bit_now ^ !uni : bit_now;
        if (idx == 4'h0) begin
          next_cv_state = CV_IDLE;
        end
      end else if (idx == 4'h0) begin
        next_cv_state = CV_DONE;
      end
    end else if (cv_state == CV_DONE && buf_in_ready) begin
      // a full buffer stalls here; strobe stays low until stored
      push = 1'b1;
      next_strobe = 1'b1;
      next_cv_state = CV_IDLE;
    end
    // busy flag registered so the pin comes straight from a flop
    next_converting = (next_cv_state == CV_EXT) ||
                      (next_cv_state == CV_INT);
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cv_state <= CV_IDLE;
      trial <= '0;
      idx <= 4'h0;
      div <= 16'h0;
      mode <= `ADCSQ_RST_MODE;
      uni <= 1'b0;
      strobe <= `ADCSQ_RST_STROBE;
      dout <= 1'b0;
      osr <= '0;
      ocnt <= 5'h0;
      converting <= 1'b0;
    end else begin
      cv_state <= next_cv_state;
      trial <= next_trial;
      idx <= next_idx;
      div <= next_div;
      mode <= next_mode;
      uni <= next_uni;
      strobe <= next_strobe;
      dout <= next_dout;
      osr <= next_osr;
      ocnt <= next_ocnt;
      converting <= next_converting;
    end
  end

  adcsq_buf #(.W(RES_W), .DEPTH(2)) u_buf (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_valid(push),
    .o_ready(buf_in_ready),
    .i_data(fmt(trial, uni)),
    .o_valid(buf_out_valid),
    .i_ready(pop),
    .o_data(buf_out)
  );

  // ****************************************************************
  // pin enables and outputs
  // ****************************************************************
  logic dout_oe, strobe_oe;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      dout_oe <= 1'b0;
      strobe_oe <= 1'b1;
    end else begin
      dout_oe <= !csn_s;
      strobe_oe <= !csn_s || mode != `ADCSQ_MODE_EXT;
    end
  end

  assign o_dout = dout;
  assign o_dout_oe = dout_oe;
  assign o_strobe = strobe;
  assign o_strobe_oe = strobe_oe;
  assign o_track = track;
  assign o_unipolar = uni;
  assign o_mode = mode;
  assign o_dac_code = trial;
  assign o_route = route;
  assign o_converting = converting;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  sequence s_ext_go;
    cmd_done && cmd_sr[1:0] == `ADCSQ_MODE_EXT;
  endsequence
  sequence s_int_go;
    cmd_done && cmd_sr[1:0] == `ADCSQ_MODE_INT;
  endsequence

  chk_dout_off: assert property (csn_s |=> !o_dout_oe)
    else $error("data out driven while deselected");
  chk_cmd_frozen: assert property (csn_s |=> $stable(cmd_sr))
    else $error("command register moved while deselected");
  chk_start_bit: assert property (rx_state == RX_SEARCH && !csn_s
      && sclk_rise && din_s |=> rx_state == RX_CMD && rx_cnt == 4'h1)
    else $error("start bit not taken");
  chk_cs_drop: assert property (csn_s |=> rx_state == RX_SEARCH)
    else $error("partial command survived deselect");
  chk_track_on: assert property (rx_state == RX_CMD && !csn_s
      && sclk_fall && rx_cnt == 4'h5 |=> o_track)
    else $error("tracking did not start after fifth bit");
  chk_hold_on: assert property (rx_state == RX_WAIT && !csn_s
      && sclk_fall |=> !o_track)
    else $error("hold not entered after eighth bit");
  chk_ext_pulse: assert property (s_ext_go |=> o_strobe [*2])
    else $error("external strobe pulse wrong");
  chk_ext_end: assert property (cv_state == CV_EXT && step
      && !cmd_done |=> !o_strobe)
    else $error("external strobe held past first step");
  chk_int_low: assert property (s_int_go |=> !o_strobe [*2])
    else $error("internal strobe not low at conversion start");
  chk_int_high: assert property (push |=> o_strobe && !o_converting)
    else $error("internal strobe not high at finish");
  chk_pd_idle: assert property (cmd_done && !cmd_sr[1]
      |=> cv_state == CV_IDLE && o_mode == $past(cmd_sr[1:0]))
    else $error("power-down command started a conversion");
  chk_route_se: assert property (rx_state == RX_CMD && sclk_fall
      && rx_cnt == 4'h6 && cmd_sr[4:0] == 5'h15
      |=> o_route.pos == 2'h1 && o_route.neg_com)
    else $error("single-ended routing wrong");
  chk_route_df: assert property (rx_state == RX_CMD && sclk_fall
      && rx_cnt == 4'h6 && cmd_sr[4:0] == 5'h18
      |=> o_route.pos == 2'h3 && o_route.neg == 2'h2 && !o_route.neg_com)
    else $error("differential routing wrong");
  chk_sar_start: assert property (s_ext_go or s_int_go
      |=> o_dac_code == MID && idx == 4'(RES_W - 1))
    else $error("approximation did not start at mid code");

endmodule : adcsq_top

// ===== bench/adcsq_host.sv
/*
 * Host serial master model driving the converter's serial port.
 * Assumes the bench calls sel and xfer; the pins are sensed after the
 * design's output enables are applied.
 */
`timescale 1ns/1ps
module adcsq_host (
  input wire logic i_mclk,
  input wire logic i_dout,
  input wire logic i_dout_oe,
  input wire logic i_track,
  input wire logic i_strobe,
  output logic o_sclk,
  output logic o_csn,
  output logic o_din
);
  // ****************************************************************
  // line model and transfers
  // ****************************************************************
  logic last = 1'b0;
  logic pin;

  // released line has no pull, so show the inverse of the last level
  always @(posedge i_mclk) begin
    if (i_dout_oe) last <= i_dout;
  end
  assign pin = i_dout_oe ? i_dout : ~last;

  initial begin
    o_sclk = 1'b0;
    o_csn = 1'b1;
    o_din = 1'b0;
  end

  task automatic sel(input logic on);
    #48;
    @(negedge i_mclk);
    #0.3;
    o_csn = ~on;
    #100;
  endtask : sel

  // clock idles low, data set on fall, taken on rise
  task automatic xfer(input logic [7:0] tx, input int nb, input int pause,
                      output logic [7:0] rx, output logic [7:0] trk,
                      output logic [7:0] stb);
    rx = 8'h00;
    trk = 8'h00;
    stb = 8'h00;
    @(negedge i_mclk);
    #0.3;
    for (int k = 0; k < nb; k++) begin
      o_din = tx[7-k];
      #24;
      o_sclk = 1'b1;
      rx = {rx[6:0], pin};
      trk[k] = i_track;
      stb[k] = i_strobe;
      #24;
      o_sclk = 1'b0;
      // stretched low phase gives the sample its settling time
      if (k == 4) #(pause);
    end
  endtask : xfer
endmodule : adcsq_host

// ===== bench/tb_adc_serial_control_sequencer.sv
/*
 * Self-checking bench of the converter control sequencer.
 * Assumes the host model in adcsq_host and a comparator modelled here.
 */
`timescale 1ns/1ps
module tb_adc_serial_control_sequencer;
  import adcsq_pkg::*;
  // ****************************************************************
  // signals and models
  // ****************************************************************
  localparam int LIMIT = 60000;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic comp_high = 1'b0;
  logic sclk, csn, din, dout, dout_oe, strobe, strobe_oe, track, uni_o;
  logic busy;
  logic [1:0] mode;
  logic [9:0] dac;
  adcsq_route_s route;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int seed = 32'hF209FE0D;
  logic [9:0] vin = 10'h000;
  logic [2:0] tbl [4] = '{3'h1, 3'h5, 3'h2, 3'h6};

  always #2.5 i_mclk = ~i_mclk;
  always @(negedge i_mclk) comp_high <= (vin >= dac);

  adcsq_top #(.STEP_CYC(4)) dut (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_sclk(sclk), .i_csn(csn),
    .i_din(din), .i_comp_high(comp_high), .o_dout(dout),
    .o_dout_oe(dout_oe), .o_strobe(strobe), .o_strobe_oe(strobe_oe),
    .o_track(track), .o_unipolar(uni_o), .o_converting(busy),
    .o_mode(mode), .o_dac_code(dac), .o_route(route));

  adcsq_host host (
    .i_mclk(i_mclk), .i_dout(dout), .i_dout_oe(dout_oe), .i_track(track),
    .i_strobe(strobe), .o_sclk(sclk), .o_csn(csn), .o_din(din));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [9:0] exp,
                     input logic [9:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  function automatic adcsq_route_s exp_route(input logic [2:0] c,
                                             input logic sgl);
    exp_route.pos = {c[1], c[2]};
    exp_route.neg = {c[1], ~c[2]};
    exp_route.neg_com = sgl;
  endfunction : exp_route

  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      $display("ERROR timeout expected finish seen hang");
      wrap_up();
    end
  end

  // ****************************************************************
  // one command and its readout
  // ****************************************************************
  task automatic run(input int i);
    logic [1:0] md;
    logic [2:0] ch;
    logic sgl, uni;
    logic [7:0] cmd, rx, rx2, rx3, t, s, t2;
    logic [9:0] d;
    adcsq_route_s er;
    int n;
    @(negedge i_mclk);
    md = i[1:0];
    ch = tbl[(i / 4) % 4];
    sgl = 1'($random(seed));
    uni = 1'($random(seed));
    vin = (i % 8 == 3) ? 10'h3FF : (i % 8 == 7) ? 10'h000 : 10'($random(seed));
    d = uni ? vin : {~vin[9], vin[8:0]};
    cmd = {1'b1, ch, uni, sgl, md};
    host.sel(1'b1);
    if (i % 3 == 0) begin
      host.xfer(8'hB0, 4, 0, rx, t, s);
      host.sel(1'b0);
      host.sel(1'b1);
    end
    n = {$random(seed)} % 8;
    if (n > 0) host.xfer(8'h00, n, 0, rx, t, s);
    host.xfer(cmd, 8, 1500, rx, t, s);
    chk("track", 10'h007, t[7:5]);
    repeat (10) @(negedge i_mclk);
    chk("hold", 10'h000, track);
    chk("mode", md, mode);
    chk("range", uni, uni_o);
    er = exp_route(ch, sgl);
    chk("pos", er.pos, route.pos);
    chk("com", sgl, route.neg_com);
    if (!sgl) chk("neg", er.neg, route.neg);
    if (md[1]) begin
      chk("strobe", md[0], strobe);
      chk("busy", 10'h001, busy);
      n = 0;
      while (!md[0] && strobe !== 1'b1 && n < 400) begin
        @(negedge i_mclk);
        n++;
      end
      if (!md[0]) chk("done", 10'h001, strobe);
      host.xfer(8'h00, 8, 0, rx2, t, s);
      host.xfer(8'h00, 8, 0, rx3, t, t2);
      chk("res_hi", d[9:3], rx2[6:0]);
      if (md[0]) chk("lead", 10'h000, rx2[7]);
      chk("res_lo", {d[2:0], 5'h00}, rx3);
      if (md[0]) chk("pulse", 10'h001, s);
    end else begin
      chk("idle", 10'h000, busy);
    end
    host.sel(1'b0);
    chk("dout_oe", 10'h000, dout_oe);
    chk("strb_oe", md != 2'h3, strobe_oe);
    host.xfer(8'hFF, 8, 0, rx, t, s);
    chk("ignored", md, mode);
    $display("test %0d done", i);
  endtask : run

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    repeat (15) @(negedge i_mclk);
    chk("rst_strobe", 10'h001, strobe);
    chk("rst_mode", 10'h002, mode);
    chk("rst_oe", 10'h000, dout_oe);
    chk("rst_busy", 10'h000, busy);
    @(negedge i_mclk);
    i_resetn = 1'b1;
    repeat (8) @(negedge i_mclk);
    $display("test reset done");
    for (int i = 0; i < 24; i++) run(i);
    wrap_up();
  end
endmodule : tb_adc_serial_control_sequencer
